// ---- design/uar_rx_recovery.sv ----
// Clock and data recovery for the asynchronous receive line
`timescale 1ns/1ps
module uar_rx_recovery #(
    parameter int MAX_BITS = uar_pkg::MAX_BITS_DEF
) (
    input  wire logic                clk,                  // System clock, 10 MHz
    input  wire logic                rst,                  // Synchronous reset, active high
    input  wire logic                rx_line,              // Receive pin, asynchronous
    input  wire logic                sample_tick,          // Oversampling tick, one cycle
    input  wire logic                double_speed_select,  // One selects eight samples per bit
    input  wire logic                receiver_enable_bit,  // Zero stops and flushes
    input  wire logic [3:0]          frame_bits,           // Data plus parity bits, 5 to 10
    output logic [MAX_BITS-1:0]      frame_data,           // Recovered bits, first in bit 0
    output logic                     stop_bit_error_flag,  // First stop bit was low
    output logic                     frame_strobe,         // One-cycle pulse per frame
    output logic                     frame_held,           // Held frame is valid
    output logic                     rx_busy               // Frame in progress
);

    // Elaboration check: the bit index is four bits wide
    if (MAX_BITS < uar_pkg::MIN_BITS || MAX_BITS > 15) begin : g_bad_width
        $error("MAX_BITS out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Line synchronizer and sample history

    logic line_s;
    logic last_sample_r;
    logic last_sample_nxt;

    uar_line_sync u_sync (
        .clk       (clk),
        .rst       (rst),
        .line_in   (rx_line),
        .line_sync (line_s)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decode

    logic [4:0] spb;
    logic [4:0] vote_lo;
    logic [4:0] vote_hi;
    logic [4:0] rearm_at;

    assign spb      = double_speed_select ? uar_pkg::DS_SPB : uar_pkg::NORM_SPB;
    assign vote_lo  = double_speed_select ? uar_pkg::DS_VOTE_LO : uar_pkg::NORM_VOTE_LO;
    assign vote_hi  = double_speed_select ? uar_pkg::DS_VOTE_HI : uar_pkg::NORM_VOTE_HI;
    assign rearm_at = double_speed_select ? uar_pkg::DS_REARM : uar_pkg::NORM_REARM;

    ////////////////////////////////////////////////////////////////////////////////
    // State and counters

    uar_pkg::uar_state_type state_r;
    uar_pkg::uar_state_type state_nxt;
    logic [4:0]             cnt_r;
    logic [4:0]             cnt_nxt;
    logic [4:0]             samp_no;
    logic [3:0]             bit_idx_r;
    logic [3:0]             bit_idx_nxt;

    logic in_window;
    logic at_vote;
    logic at_bit_end;
    logic at_rearm;
    logic start_edge;
    logic vote;
    logic last_data_bit;
    logic run;

    assign run           = receiver_enable_bit;
    // Count holds the last sample taken, so a tick sees the next number
    assign samp_no       = cnt_r + 5'h01;
    assign in_window     = (samp_no >= vote_lo) && (samp_no < vote_hi);
    assign at_vote       = sample_tick && (samp_no == vote_hi);
    assign at_bit_end    = sample_tick && (cnt_r >= spb);
    assign at_rearm      = sample_tick && (samp_no >= rearm_at);
    assign start_edge    = sample_tick && last_sample_r && !line_s;
    assign last_data_bit = (bit_idx_r == frame_bits - 4'h1);
    assign last_sample_nxt = sample_tick ? line_s : last_sample_r;

    uar_vote3 u_vote (
        .clk       (clk),
        .rst       (rst),
        .clear     (state_r == uar_pkg::ST_IDLE),
        .shift     (sample_tick && in_window),
        .sample_in (line_s),
        .vote_now  (vote)
    );

    always_comb begin
        state_nxt   = state_r;
        cnt_nxt     = sample_tick ? cnt_r + 5'h01 : cnt_r;
        bit_idx_nxt = bit_idx_r;
        unique case (state_r)
            uar_pkg::ST_IDLE: begin
                cnt_nxt     = cnt_r;
                bit_idx_nxt = 4'h0;
                if (start_edge) begin
                    state_nxt = uar_pkg::ST_START;
                    cnt_nxt   = uar_pkg::SAMPLE_FIRST;
                end
            end
            uar_pkg::ST_START: begin
                if (at_vote && vote) begin
                    state_nxt = uar_pkg::ST_IDLE;
                end else if (at_bit_end) begin
                    state_nxt = uar_pkg::ST_DATA;
                    cnt_nxt   = uar_pkg::SAMPLE_FIRST;
                end
            end
            uar_pkg::ST_DATA: begin
                if (at_bit_end) begin
                    cnt_nxt = uar_pkg::SAMPLE_FIRST;
                    if (last_data_bit) begin
                        state_nxt = uar_pkg::ST_STOP;
                    end else begin
                        bit_idx_nxt = bit_idx_r + 4'h1;
                    end
                end
            end
            uar_pkg::ST_STOP: begin
                if (at_rearm) begin
                    state_nxt = uar_pkg::ST_IDLE;
                end
            end
        endcase
        if (!run) begin
            state_nxt   = uar_pkg::ST_IDLE;
            bit_idx_nxt = 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r       <= uar_pkg::ST_IDLE;
            cnt_r         <= 5'h00;
            bit_idx_r     <= 4'h0;
            last_sample_r <= uar_pkg::LINE_IDLE;
        end else begin
            state_r       <= state_nxt;
            cnt_r         <= cnt_nxt;
            bit_idx_r     <= bit_idx_nxt;
            last_sample_r <= last_sample_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shift data and hold the finished frame

    logic [MAX_BITS-1:0] shift_r;
    logic [MAX_BITS-1:0] shift_nxt;
    logic                data_vote;
    logic                stop_vote;

    assign data_vote = run && (state_r == uar_pkg::ST_DATA) && at_vote;
    assign stop_vote = run && (state_r == uar_pkg::ST_STOP) && at_vote;

    always_comb begin
        shift_nxt = shift_r;
        if (state_r == uar_pkg::ST_START) begin
            shift_nxt = '0;
        end else if (data_vote) begin
            shift_nxt[bit_idx_r] = vote;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            shift_r <= '0;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    // Data and error status move out together on the stop vote
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            frame_data          <= '0;
            stop_bit_error_flag <= 1'b0;
            frame_strobe        <= 1'b0;
            frame_held          <= 1'b0;
        end else begin
            frame_strobe <= stop_vote;
            if (stop_vote) begin
                frame_data          <= shift_r;
                stop_bit_error_flag <= !vote;
                frame_held          <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_busy <= 1'b0;
        end else begin
            rx_busy <= (state_nxt != uar_pkg::ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_tick_gates_count: assert property (
        @(posedge clk) disable iff (rst)
        (run && state_r != uar_pkg::ST_IDLE && !sample_tick) |=> $stable(cnt_r))
        else $error("sample count moved without a tick");

    chk_start_restarts_one: assert property (
        @(posedge clk) disable iff (rst)
        (run && state_r == uar_pkg::ST_IDLE && sample_tick && last_sample_r && !line_s)
        |=> (state_r == uar_pkg::ST_START && cnt_r == uar_pkg::SAMPLE_FIRST))
        else $error("start edge did not restart count at one");

    chk_noise_rejected: assert property (
        @(posedge clk) disable iff (rst)
        (state_r == uar_pkg::ST_START && sample_tick && samp_no == vote_hi && vote)
        |=> state_r == uar_pkg::ST_IDLE)
        else $error("noisy start not rejected");

    chk_start_accepted: assert property (
        @(posedge clk) disable iff (rst)
        (run && state_r == uar_pkg::ST_START && sample_tick && samp_no == vote_hi && !vote)
        |=> state_r == uar_pkg::ST_START)
        else $error("valid start dropped");

    chk_count_in_range: assert property (
        @(posedge clk) disable iff (rst)
        (state_r != uar_pkg::ST_IDLE) |-> (cnt_r >= uar_pkg::SAMPLE_FIRST && cnt_r <= spb))
        else $error("sample count outside bit");

    chk_data_vote_kept: assert property (
        @(posedge clk) disable iff (rst)
        data_vote |=> shift_r[$past(bit_idx_r)] == $past(vote))
        else $error("data bit not taken from vote");

    chk_stop_after_bits: assert property (
        @(posedge clk) disable iff (rst)
        (run && state_r == uar_pkg::ST_DATA && at_bit_end && last_data_bit)
        |=> state_r == uar_pkg::ST_STOP)
        else $error("stop bit not reached after frame bits");

    chk_frame_error: assert property (
        @(posedge clk) disable iff (rst)
        stop_vote |=> (frame_strobe && frame_held && stop_bit_error_flag == !$past(vote)))
        else $error("framing error not reported");

    chk_normal_rearm: assert property (
        @(posedge clk) disable iff (rst)
        (stop_vote && !double_speed_select) |=> state_r == uar_pkg::ST_IDLE)
        else $error("normal mode not rearmed after stop vote");

    chk_disable_flush: assert property (
        @(posedge clk) disable iff (rst)
        !run |=> (state_r == uar_pkg::ST_IDLE && !frame_held && !frame_strobe))
        else $error("disable did not flush");

    chk_error_held: assert property (
        @(posedge clk) disable iff (rst)
        (run && frame_held && !stop_vote) |=> $stable(stop_bit_error_flag))
        else $error("held error status changed");

    chk_busy_follows_state: assert property (
        @(posedge clk) disable iff (rst)
        rx_busy == (state_r != uar_pkg::ST_IDLE))
        else $error("busy flag differs from receiver state");

    chk_stop_rearm_idle: assert property (
        @(posedge clk) disable iff (rst)
        (run && state_r == uar_pkg::ST_STOP && at_rearm)
        |=> state_r == uar_pkg::ST_IDLE)
        else $error("extra stop samples not ignored");

    chk_double_rearm_late: assert property (
        @(posedge clk) disable iff (rst)
        (stop_vote && double_speed_select) |=> state_r == uar_pkg::ST_STOP)
        else $error("double speed rearmed before its earliest start");

    chk_strobe_single: assert property (
        @(posedge clk) disable iff (rst)
        frame_strobe |=> !frame_strobe)
        else $error("frame strobe longer than one cycle");

    chk_held_stays: assert property (
        @(posedge clk) disable iff (rst)
        (run && frame_held) |=> frame_held)
        else $error("held frame lost while enabled");

    chk_start_clears_data: assert property (
        @(posedge clk) disable iff (rst)
        (run && state_r == uar_pkg::ST_START)
        |=> shift_r == '0)
        else $error("shift register not cleared for new frame");

    chk_bit_advance: assert property (
        @(posedge clk) disable iff (rst)
        (run && state_r == uar_pkg::ST_DATA && at_bit_end && !last_data_bit)
        |=> (state_r == uar_pkg::ST_DATA && cnt_r == uar_pkg::SAMPLE_FIRST
             && bit_idx_r == $past(bit_idx_r) + 4'h1))
        else $error("bit timing not restarted at the next bit");

    chk_idle_needs_edge: assert property (
        @(posedge clk) disable iff (rst)
        (state_r == uar_pkg::ST_IDLE && !start_edge) |=> state_r == uar_pkg::ST_IDLE)
        else $error("left idle without a start edge");

endmodule

// ---- design/uar_pkg.sv ----
// Constants and types for the asynchronous receive front end
package uar_pkg;

    localparam int        CNT_W          = 5;
    localparam logic [4:0] SAMPLE_FIRST  = 5'h01;
    localparam logic [4:0] NORM_SPB      = 5'h10;
    localparam logic [4:0] DS_SPB        = 5'h08;
    localparam logic [4:0] NORM_VOTE_LO  = 5'h08;
    localparam logic [4:0] NORM_VOTE_HI  = 5'h0a;
    localparam logic [4:0] DS_VOTE_LO    = 5'h04;
    localparam logic [4:0] DS_VOTE_HI    = 5'h06;
    localparam logic [4:0] NORM_REARM    = 5'h0a;
    localparam logic [4:0] DS_REARM      = 5'h07;
    localparam int        MIN_BITS       = 5;
    localparam int        MAX_BITS_DEF   = 10;
    localparam logic      LINE_IDLE      = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_DATA  = 2'b10,
        ST_STOP  = 2'b11
    } uar_state_type;

endpackage

// ---- design/uar_line_sync.sv ----
// Two-stage synchronizer for the receive line
`timescale 1ns/1ps
module uar_line_sync (
    input  wire logic clk,       // System clock
    input  wire logic rst,       // Synchronous reset, active high
    input  wire logic line_in,   // Asynchronous receive pin
    output logic      line_sync  // Synchronized line level
);
    logic meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r    <= uar_pkg::LINE_IDLE;
            line_sync <= uar_pkg::LINE_IDLE;
        end else begin
            meta_r    <= line_in;
            line_sync <= meta_r;
        end
    end
endmodule

// ---- design/uar_vote3.sv ----
// Three-sample majority voter with a two-deep history
`timescale 1ns/1ps
module uar_vote3 (
    input  wire logic clk,       // System clock
    input  wire logic rst,       // Synchronous reset, active high
    input  wire logic clear,     // Drop stored samples
    input  wire logic shift,     // Store the current sample
    input  wire logic sample_in, // Current line sample
    output logic      vote_now   // Majority of two stored and current
);
    logic [1:0] hist_r;
    logic [1:0] hist_nxt;

    assign hist_nxt = clear ? 2'h0 : (shift ? {hist_r[0], sample_in} : hist_r);
    // Two or three high samples give one
    assign vote_now = (hist_r[1] & hist_r[0]) | (hist_r[1] & sample_in)
                    | (hist_r[0] & sample_in);

    always_ff @(posedge clk) begin
        if (rst) begin
            hist_r <= 2'h0;
        end else begin
            hist_r <= hist_nxt;
        end
    end
endmodule

// ---- tb/uar_tx_model.sv ----
// Remote asynchronous transmitter model driving the receive line
`timescale 1ns/1ps
module uar_tx_model (
    input  wire logic clk,          // System clock
    input  wire logic sample_tick,  // Oversampling tick
    output logic      line          // Serial line, idle high
);
    ////////////////////////////////////////////////////////////////////////
    initial line = 1'b1;

    // One sample period per call, changed right after a tick
    task automatic put(input logic v);
        @(negedge clk);
        line = v;
        @(posedge clk iff sample_tick);
    endtask

    task automatic idle(input int n);
        repeat (n) put(1'b1);
    endtask

    // Start bit, bits first to last, then one stop of stop_n samples
    task automatic send(input logic [9:0] d, input int nb, input int spb,
                        input logic stop_v, input int stop_n, input logic glitch);
        logic b;
        int   n;
        for (int i = 0; i <= nb + 1; i++) begin
            b = (i == 0) ? 1'b0 : (i > nb) ? stop_v : d[i-1];
            n = (i > nb) ? stop_n : spb;
            for (int s = 1; s <= n; s++) begin
                put(b ^ (glitch && s == spb / 2 + 1));
            end
        end
    endtask
endmodule

// ---- tb/uar_rx_recovery_tb.sv ----
// Self-checking bench for the receive clock and data recovery
`timescale 1ns/1ps
module uar_rx_recovery_tb;
    logic        clk;
    logic        rst;
    logic        rx_line;
    logic        sample_tick = 1'b0;
    logic        double_speed_select;
    logic        receiver_enable_bit;
    logic [3:0]  frame_bits;
    logic [9:0]  frame_data;
    logic        stop_bit_error_flag;
    logic        frame_strobe;
    logic        frame_held;
    logic        rx_busy;
    logic [10:0] exp_q[$];
    logic [10:0] last;
    int          fails = 0;
    int          total_checks = 0;
    int          tdiv = 0;
    int          spb;

    uar_rx_recovery #(.MAX_BITS(10)) dut (
        .clk(clk), .rst(rst), .rx_line(rx_line), .sample_tick(sample_tick),
        .double_speed_select(double_speed_select),
        .receiver_enable_bit(receiver_enable_bit), .frame_bits(frame_bits),
        .frame_data(frame_data), .stop_bit_error_flag(stop_bit_error_flag),
        .frame_strobe(frame_strobe), .frame_held(frame_held), .rx_busy(rx_busy)
    );

    uar_tx_model tx (.clk(clk), .sample_tick(sample_tick), .line(rx_line));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Oversampling tick every fourth clock
    always @(negedge clk) begin
        tdiv <= (tdiv == 3) ? 0 : tdiv + 1;
        sample_tick <= (tdiv == 3);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check_frame(input logic [10:0] got, input logic [10:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t frame got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_held(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t held got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic check_busy(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t busy got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Oldest note is taken on each strobe; held data must not drift
    always @(negedge clk) begin
        if (frame_strobe === 1'b1) begin
            last = (exp_q.size() != 0) ? exp_q.pop_front() : 11'bx;
            check_frame({stop_bit_error_flag, frame_data}, last);
        end else if (frame_held === 1'b1) begin
            check_frame({stop_bit_error_flag, frame_data}, last);
        end
    end

    // Width is set one tick into the start bit, after the last strobe
    task automatic frame(input int nb, input logic stop_v, input int stop_n,
                         input logic glitch);
        logic [9:0] d;
        d = 10'($urandom());
        exp_q.push_back({~stop_v, d & (10'h3ff >> (10 - nb))});
        fork
            tx.send(d, nb, spb, stop_v, stop_n, glitch);
            begin
                @(posedge clk iff sample_tick);
                @(negedge clk);
                frame_bits = 4'(nb);
            end
        join
        if (!stop_v) tx.idle(spb);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hc2a5c389));
        rst = 1'b1;
        double_speed_select = 1'b0;
        receiver_enable_bit = 1'b1;
        frame_bits = 4'h5;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        check_held(frame_held, 1'b0);
        tx.idle(4);
        for (int m = 0; m < 2; m++) begin
            double_speed_select = m[0];
            spb = m ? 8 : 16;
            tx.idle(spb);
            for (int nb = 5; nb <= 10; nb++) begin
                frame(nb, 1'b1, spb, 1'($urandom() % 2));
            end
            frame(8, 1'b0, spb, 1'b0);
            repeat (spb / 2) tx.put(1'b0);
            tx.idle(spb * 2);
            frame(7, 1'b1, m ? 7 : 10, 1'b0);
            frame(9, 1'b1, m ? 7 : 10, 1'b1);
            frame(6, 1'b0, spb, 1'b1);
            tx.idle(spb);
            fork
                tx.send(10'h2a5, 10, spb, 1'b1, spb, 1'b0);
                begin
                    repeat (spb * 4) @(posedge clk iff sample_tick);
                    @(negedge clk);
                    check_busy(rx_busy, 1'b1);
                    receiver_enable_bit = 1'b0;
                    repeat (2) @(negedge clk);
                    check_held(frame_held, 1'b0);
                    check_busy(rx_busy, 1'b0);
                end
            join
            receiver_enable_bit = 1'b1;
            tx.idle(spb);
            frame(10, 1'b1, spb, 1'b0);
            tx.idle(spb * 2);
        end
        total_checks++;
        if (exp_q.size() != 0) begin
            fails++;
            $display("MISMATCH t=%0t %0d frames missing", $time, exp_q.size());
        end
        final_report();
    end

    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        final_report();
    end
endmodule
